//--- inc/bsscd_consts.vh
// Purpose: Constants for the bit-set / bit-test-skip / call decode block
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes:   Opcode fields sit in the top bits of the instruction word
`ifndef BSSCD_CONSTS_VH
`define BSSCD_CONSTS_VH

// Instruction word layout
`define BSSCD_IW_W          14
`define BSSCD_PC_W          13
`define BSSCD_REGA_W        7
`define BSSCD_OP4_MSB       13
`define BSSCD_OP4_LSB       10
`define BSSCD_OP3_MSB       13
`define BSSCD_OP3_LSB       11
`define BSSCD_BIT_MSB       9
`define BSSCD_BIT_LSB       7
`define BSSCD_REG_MSB       6
`define BSSCD_REG_LSB       0
`define BSSCD_LIT_MSB       10
`define BSSCD_LIT_LSB       0

// Opcodes
`define BSSCD_OPC_BSET      4'h5
`define BSSCD_OPC_BTSS      4'h7
`define BSSCD_OPC_CALL      3'h4

// Upper latch bits copied into PC<12:11>
`define BSSCD_ULATCH_MSB    4
`define BSSCD_ULATCH_LSB    3

// Phase codes (Q1..Q4) and reset values
`define BSSCD_Q1            2'h0
`define BSSCD_Q2            2'h1
`define BSSCD_Q3            2'h2
`define BSSCD_Q4            2'h3
`define BSSCD_PC_RST        13'h0000
`define BSSCD_BYTE_RST      8'h00

`endif

//--- rtl/bsscd_phase_gen.v
// Purpose: Four-phase instruction cycle generator
// Assumes: One phase per input clock period
// Notes:   Phase restarts at Q1 after reset and after every Q4
`include "bsscd_consts.vh"
`timescale 1ns/100ps

module bsscd_phase_gen
(
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Phase out
    output reg  [1:0] phase_o
);

    // Wrapping phase counter
    always @(posedge clk_i)
    begin
        if (rst_i)
            phase_o <= `BSSCD_Q1;
        else
            phase_o <= phase_o + 2'h1;
    end

endmodule // bsscd_phase_gen

//--- rtl/bsscd_decode.v
// Purpose: Decode and execute bit set, bit test skip if one, and call
// Assumes: Register file and stack storage lie outside; instruction word
//          is held stable by the fetch logic for a whole cycle
// Notes:   Other opcodes write nothing here; other 01xx opcodes still issue a register read
// Functional notes
// - Bit set: 3-bit index, 7-bit address; forces bit high, flags untouched.
// - Bit test skip: tested bit zero lets next instruction run normally.
// - Tested bit one: fetched next instruction discarded, no-op instead, two cycles.
// - Test cycle: decode, read, process, no write; skip cycle does nothing.
// - Call pushes address of following instruction and redirects PC on the same Q4 edge.
// - Call copies upper latch bits four and three into PC twelve, eleven.
// - Call recognised by opcode plus literal; two cycles; flags untouched.
// - Call: decode, read literal, process, write PC and push in Q4; then no-op.
`include "bsscd_consts.vh"
`timescale 1ns/100ps

module bsscd_decode
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Instruction and program counter from fetch
    input  wire [13:0] instr_i,
    input  wire [12:0] pc_i,
    input  wire [7:0]  pc_upper_latch_i,
    // Register file read data
    input  wire [7:0]  reg_rdata_i,
    // Phase indication
    output reg  [1:0]  phase_o,
    // Register file access
    output reg         reg_rd_o,
    output reg  [6:0]  reg_addr_o,
    output reg         reg_wr_o,
    output reg  [7:0]  reg_wdata_o,
    // Program counter load
    output reg         pc_load_o,
    output reg  [12:0] pc_new_o,
    // Return stack push
    output reg         stack_push_o,
    output reg  [12:0] stack_top_o,
    // Cycle status
    output reg         nop_cycle_o,
    output reg         flags_we_o
);

    // Internal phase and decode state
    wire [1:0]  phase;
    wire        bit_set_op;
    wire        bit_test_skip_if_one_op;
    wire        call_op;
    wire [2:0]  bit_idx;
    wire [6:0]  reg_addr;
    wire [10:0] lit;
    wire        bit_class;      // Any 01xx opcode outside a skip slot reads its register
    wire [12:0] ret_addr;       // Address pushed by a call
    reg         skip_ff;        // Next cycle is a discarded slot
    reg         nxt_skip;
    reg         busy_ff;        // Current cycle is a forced no-op
    reg  [7:0]  data_ff;        // Operand latched in Q2
    reg  [7:0]  result_ff;      // Result built in Q3
    reg  [7:0]  bit_mask;
    reg  [12:0] call_target;

    bsscd_phase_gen u_phase
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .phase_o (phase)
    );

    // Field extraction
    assign bit_idx  = instr_i[`BSSCD_BIT_MSB:`BSSCD_BIT_LSB];
    assign reg_addr = instr_i[`BSSCD_REG_MSB:`BSSCD_REG_LSB];
    assign lit      = instr_i[`BSSCD_LIT_MSB:`BSSCD_LIT_LSB];
    assign bit_class = (instr_i[13:12] == 2'h1);
    // Return address is the instruction after the call
    assign ret_addr  = pc_i + 13'h0001;
    // Opcode match, gated off during a forced no-op cycle
    assign bit_set_op = !busy_ff &&
        (instr_i[`BSSCD_OP4_MSB:`BSSCD_OP4_LSB] == `BSSCD_OPC_BSET);
    assign bit_test_skip_if_one_op = !busy_ff &&
        (instr_i[`BSSCD_OP4_MSB:`BSSCD_OP4_LSB] == `BSSCD_OPC_BTSS);
    assign call_op = !busy_ff &&
        (instr_i[`BSSCD_OP3_MSB:`BSSCD_OP3_LSB] == `BSSCD_OPC_CALL);

    // Mask and call target
    always @*
    begin
        case (bit_idx)
            3'h0:    bit_mask = 8'h01;
            3'h1:    bit_mask = 8'h02;
            3'h2:    bit_mask = 8'h04;
            3'h3:    bit_mask = 8'h08;
            3'h4:    bit_mask = 8'h10;
            3'h5:    bit_mask = 8'h20;
            3'h6:    bit_mask = 8'h40;
            default: bit_mask = 8'h80;
        endcase
        call_target = {pc_upper_latch_i[`BSSCD_ULATCH_MSB:`BSSCD_ULATCH_LSB],
                       lit};
    end

    // Skip decision, taken in Q3 of a test or call cycle
    always @*
    begin
        nxt_skip = skip_ff;
        if (phase == `BSSCD_Q3 && bit_test_skip_if_one_op)
            nxt_skip = |(data_ff & bit_mask);
        else if (phase == `BSSCD_Q3 && call_op)
            nxt_skip = 1'b1;
        else if (phase == `BSSCD_Q4 && busy_ff)
            nxt_skip = 1'b0;
    end

    // Phase mirror, pending skip and forced no-op tracking
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_o     <= `BSSCD_Q1;
            skip_ff     <= 1'b0;
            busy_ff     <= 1'b0;
            nop_cycle_o <= 1'b0;
        end
        else
        begin
            phase_o <= phase;
            skip_ff <= nxt_skip;
            // Decided in Q1 and held for the whole cycle
            if (phase == `BSSCD_Q1)
            begin
                busy_ff     <= skip_ff;
                nop_cycle_o <= skip_ff;
            end
        end
    end

    // Operand latched in Q2, bit-set result built in Q3
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_ff   <= `BSSCD_BYTE_RST;
            result_ff <= `BSSCD_BYTE_RST;
        end
        else
        begin
            if (phase == `BSSCD_Q2)
                data_ff <= reg_rdata_i;
            if (phase == `BSSCD_Q3)
                result_ff <= data_ff | bit_mask;
        end
    end

    // Read request in Q1, bit-set write-back in Q4
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_rd_o    <= 1'b0;
            reg_addr_o  <= 7'h00;
            reg_wr_o    <= 1'b0;
            reg_wdata_o <= `BSSCD_BYTE_RST;
        end
        else
        begin
            reg_rd_o <= 1'b0;
            reg_wr_o <= 1'b0;
            case (phase)
                `BSSCD_Q1:
                begin
                    // A pending skip suppresses the read as well
                    if (!skip_ff && bit_class)
                    begin
                        reg_rd_o   <= 1'b1;
                        reg_addr_o <= reg_addr;
                    end
                end
                `BSSCD_Q4:
                begin
                    if (bit_set_op)
                    begin
                        reg_wr_o    <= 1'b1;
                        reg_addr_o  <= reg_addr;
                        reg_wdata_o <= result_ff;
                    end
                end
                default:
                begin
                    reg_rd_o <= 1'b0;
                end
            endcase
        end
    end

    // Call: push return address and load new PC at the end of Q4
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_load_o    <= 1'b0;
            pc_new_o     <= `BSSCD_PC_RST;
            stack_push_o <= 1'b0;
            stack_top_o  <= `BSSCD_PC_RST;
        end
        else
        begin
            pc_load_o    <= 1'b0;
            stack_push_o <= 1'b0;
            if (phase == `BSSCD_Q4 && call_op)
            begin
                stack_push_o <= 1'b1;
                stack_top_o  <= ret_addr;
                pc_load_o    <= 1'b1;
                pc_new_o     <= call_target;
            end
        end
    end

    // Status flags are never written by these instructions
    always @(posedge clk_i)
    begin
        if (rst_i)
            flags_we_o <= 1'b0;
        else
            flags_we_o <= 1'b0;
    end

endmodule // bsscd_decode

//--- sim/bsscd_checker.sv
// Purpose: Port assertions for the decode block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to bsscd_decode from the bench top
`timescale 1ns/100ps
module bsscd_checker
(
    // Clock and reset
    input wire       clk_i,
    input wire       rst_i,
    // Watched outputs
    input wire [1:0] phase_o,
    input wire       reg_rd_o,
    input wire       reg_wr_o,
    input wire [7:0] reg_wdata_o,
    input wire       pc_load_o,
    input wire       stack_push_o,
    input wire       nop_cycle_o,
    input wire       flags_we_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_flags_quiet: assert property (!flags_we_o) else $error("flags written");
    chk_phase_step: assert property ($changed(phase_o) |-> phase_o == $past(phase_o) + 2'h1)
        else $error("phase skipped");
    chk_phase_wrap: assert property (phase_o == 2'h3 |=> phase_o == 2'h0)
        else $error("phase not back to Q1");
    chk_rd_once: assert property (reg_rd_o |=> !reg_rd_o [*3]) else $error("extra read");
    chk_wr_after_rd: assert property (reg_wr_o |-> $past(reg_rd_o, 3))
        else $error("write without read");
    chk_wr_bit_set: assert property (reg_wr_o |-> reg_wdata_o != 8'h00)
        else $error("no bit forced");
    chk_push_load_pair: assert property (stack_push_o |-> pc_load_o && !reg_wr_o)
        else $error("push without load");
    chk_call_no_read: assert property (pc_load_o |-> !$past(reg_rd_o, 3))
        else $error("call read a register");
    chk_call_then_nop: assert property (stack_push_o |-> ##[0:4] nop_cycle_o)
        else $error("no idle cycle after call");
    // Main scenarios seen
    cov_write: cover property (reg_wr_o);
    cov_call: cover property (stack_push_o);
    cov_skip: cover property ($rose(nop_cycle_o) && !pc_load_o);
endmodule // bsscd_checker

//--- sim/bit_set_skip_call_decode_tb_top.sv
// Purpose: Random and corner tests of the decode block
// Assumes: Instruction advanced every four clocks at the falling edge
// Notes:   Pulses checked against queues, so exact phase offset is free
`include "bsscd_consts.vh"
`timescale 1ns/100ps
module bit_set_skip_call_decode_tb_top;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [13:0] instr_i = 14'h0000;
    reg  [12:0] pc_i = 13'h0000;
    reg  [7:0]  pc_upper_latch_i = 8'h00;
    reg  [7:0]  mem [0:127];
    wire [7:0]  reg_rdata_i;
    wire [6:0]  reg_addr_o;
    wire [7:0]  reg_wdata_o;
    wire [12:0] pc_new_o;
    wire [12:0] stack_top_o;
    wire [1:0]  phase_o;
    wire        reg_rd_o, reg_wr_o, pc_load_o, stack_push_o, nop_cycle_o, flags_we_o;
    reg  [12:0] q_wd[$], q_st[$], q_pc[$], q_wa[$];
    integer     seed = 68, bad_count = 0, num_checks = 0, nops = 0, exp_nops = 0, i;
    reg         skip_nxt = 1'b0;
    reg  [15:0] r;
    // Clock and register file model
    always #50 clk_i = ~clk_i;
    assign reg_rdata_i = mem[reg_addr_o];
    bsscd_decode dut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .pc_i(pc_i),
        .pc_upper_latch_i(pc_upper_latch_i), .reg_rdata_i(reg_rdata_i), .phase_o(phase_o),
        .reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o),
        .reg_wdata_o(reg_wdata_o), .pc_load_o(pc_load_o), .pc_new_o(pc_new_o),
        .stack_push_o(stack_push_o), .stack_top_o(stack_top_o), .nop_cycle_o(nop_cycle_o),
        .flags_we_o(flags_we_o));
    task check(input string nm, input [12:0] e, input [12:0] g);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task complete_run;
    begin
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    // Expected write-back value and call target
    function [12:0] exp_wdata(input [7:0] d, input [2:0] b);
        exp_wdata = {5'h00, d | (8'h01 << b)};
    endfunction
    function [12:0] exp_target(input [7:0] ul, input [10:0] k);
        exp_target = {ul[4:3], k};
    endfunction
    // Present one instruction and queue what it must do
    task issue(input [13:0] iw);
        reg was;
    begin
        was = skip_nxt;
        instr_i = iw;
        pc_i = $random(seed);
        pc_upper_latch_i = $random(seed);
        if (was)
            skip_nxt = 1'b0;
        else if (iw[13:10] == `BSSCD_OPC_BSET)
        begin
            q_wd.push_back(exp_wdata(mem[iw[6:0]], iw[9:7]));
            q_wa.push_back({6'h00, iw[6:0]});
        end
        else if (iw[13:10] == `BSSCD_OPC_BTSS)
            skip_nxt = mem[iw[6:0]][iw[9:7]];
        else if (iw[13:11] == `BSSCD_OPC_CALL)
        begin
            q_st.push_back(pc_i + 13'h0001);
            q_pc.push_back(exp_target(pc_upper_latch_i, iw[10:0]));
            skip_nxt = 1'b1;
        end
        if (skip_nxt && !was)
            exp_nops = exp_nops + 4;
        repeat (4) @(negedge clk_i);
    end
    endtask
    // Watch pulses and idle cycles
    always @(negedge clk_i)
        if (!rst_i)
        begin
            if (nop_cycle_o === 1'b1)
                nops = nops + 1;
            if (reg_wr_o !== 1'b0)
            begin
                check("wdata", q_wd.size() ? q_wd.pop_front() : 13'h1fff, reg_wdata_o);
                check("waddr", q_wa.size() ? q_wa.pop_front() : 13'h1fff, reg_addr_o);
            end
            if (stack_push_o !== 1'b0)
                check("stack", q_st.size() ? q_st.pop_front() : 13'h1fff, stack_top_o);
            if (pc_load_o !== 1'b0)
                check("pcnew", q_pc.size() ? q_pc.pop_front() : 13'h1fff, pc_new_o);
        end
    // Main sequence
    initial
    begin
        for (i = 0; i < 128; i = i + 1)
            mem[i] = $random(seed);
        mem[0] = 8'h00;
        mem[1] = 8'h0a;
        mem[127] = 8'h80;
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        issue({`BSSCD_OPC_BTSS, 3'h0, 7'h00});
        issue({`BSSCD_OPC_BSET, 3'h7, 7'h01});
        issue({`BSSCD_OPC_BTSS, 3'h7, 7'h7f});
        issue({`BSSCD_OPC_BSET, 3'h7, 7'h01});
        issue({`BSSCD_OPC_CALL, 11'h7ff});
        issue({`BSSCD_OPC_CALL, 11'h000});
        for (i = 0; i < 200; i = i + 1)
        begin
            r = $random(seed);
            case (r[15:14])
                2'h0: issue({`BSSCD_OPC_BSET, r[9:0]});
                2'h1: issue({`BSSCD_OPC_BTSS, r[9:0]});
                2'h2: issue({`BSSCD_OPC_CALL, r[10:0]});
                default: issue({2'h0, r[11:0]});
            endcase
        end
        repeat (3) issue(14'h0000);
        check("nops", exp_nops, nops);
        check("left", 13'h0000, q_wd.size() + q_st.size() + q_pc.size());
        check("wa_left", 13'h0000, q_wa.size());
        complete_run;
    end
    // Hang guard
    initial
    begin
        #100000;
        bad_count = bad_count + 1;
        complete_run;
    end
endmodule // bit_set_skip_call_decode_tb_top
bind bsscd_decode bsscd_checker chk (.clk_i(clk_i), .rst_i(rst_i), .phase_o(phase_o),
    .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
    .pc_load_o(pc_load_o), .stack_push_o(stack_push_o), .nop_cycle_o(nop_cycle_o),
    .flags_we_o(flags_we_o));
